/* File: fosc_pkg.sv */
// Package for the filter output and start control block
package fosc_pkg;
  localparam int ACC_W = 40;      // Output register width, top accumulator bits
  localparam int OUT_W = 24;      // Output bus width
  localparam int ACC_IN_W = 43;   // Full accumulator width
  localparam int ACC_DROP = 3;    // Low accumulator bits not kept
  localparam int DATA_W = 16;     // Accuracy held through both stages
  // Output register bit positions (weight 2^8 at bit 39, 2^-31 at bit 0)
  localparam int POS_HI_SEL = 39; // Upper byte, select high: 2^8..2^1
  localparam int POS_HI_LOW = 15; // Upper byte, select low: 2^-16..2^-23
  localparam int POS_LO_NRM = 31; // Low word, no bypass: 2^0..2^-15
  localparam int POS_LO_BYP = 15; // Low word, bypass: 2^-16..2^-31
  localparam logic [23:0] OUT_RST = 24'h000000;
  localparam logic [39:0] ACC_RST = 40'h0000000000;

  typedef struct packed {
    logic upper_byte_select;
    logic final_stage_bypass;
  } fosc_sel_s;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN} fosc_run_e;
endpackage

/* File: fosc_top.sv */
// Output formatter, output-valid strobe and start control
// Notes on behaviour
// - Output-valid strobe rises when a new result sits on the output bus.
// - Both filter stages keep sixteen bits of accuracy.
// - Output bit weights follow bypass and upper byte select settings.
// - Reset, configure, then start; data ignored until start.
// - Async start synchronised, drives cascade output and internal start.
// - Sync start pulse, already synchronous, starts operation directly.
// - Cascade output timed so fed device starts on same clock.
// - Start recognised only on a sampled high-to-low transition.
// - Reset holds internal start inactive.
// - Top forty accumulator bits latched; output muxes read that register.
module fosc_top
  import fosc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic async_start_n,
  input wire logic sync_start_n,
  input wire logic filter_disable,
  input wire fosc_sel_s sel,
  input wire logic [ACC_IN_W-1:0] acc_in,
  input wire logic acc_done,
  input wire logic data_in_valid,
  output logic start_cascade_out_n,
  output logic internal_start,
  output logic running,
  output logic data_accept,
  output logic [OUT_W-1:0] data_out,
  output logic data_ready
);

  logic async_meta;
  logic async_sync;
  logic async_prev;
  logic sync_prev;
  logic async_fall;
  logic sync_fall;
  logic [ACC_W-1:0] out_reg;
  logic out_new;
  fosc_run_e run_state;
  logic [OUT_W-1:0] next_data_out;
  logic strobe_arm;

  // Async start two-flop synchroniser and edge history
  always_ff @(posedge clk) begin
    if (rst) begin
      async_meta <= 1'b1;
      async_sync <= 1'b1;
      async_prev <= 1'b1;
      sync_prev <= 1'b1;
    end else begin
      async_meta <= async_start_n;
      async_sync <= async_meta;
      async_prev <= async_sync;
      sync_prev <= sync_start_n;
    end
  end

  // Falling edges only; a held-low level never restarts
  assign async_fall = async_prev & ~async_sync;
  assign sync_fall = sync_prev & ~sync_start_n;

  // Internal start pulse, OR of the sync falling edge and the low cascade output, forced off in reset
  always_ff @(posedge clk) begin
    if (rst) begin
      internal_start <= 1'b0;
      start_cascade_out_n <= 1'b1;
    end else begin
      // Async path leaves on the cascade first and re-enters through
      // it, so this block and a fed device start on the same edge
      internal_start <= sync_fall | ~start_cascade_out_n;
      start_cascade_out_n <= ~async_fall;
    end
  end

  // Run state: idle until a start, disable pauses output
  always_ff @(posedge clk) begin
    if (rst) begin
      run_state <= ST_IDLE;
    end else begin
      case (run_state)
        ST_IDLE: begin
          if (internal_start) begin
            run_state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (filter_disable) begin
            run_state <= ST_IDLE;
          end
        end
        default: run_state <= ST_IDLE;
      endcase
    end
  end

  assign running = (run_state == ST_RUN);
  assign data_accept = running & data_in_valid;

  // Output register keeps the top forty accumulator bits
  always_ff @(posedge clk) begin
    if (rst) begin
      out_reg <= ACC_RST;
      out_new <= 1'b0;
    end else begin
      out_new <= 1'b0;
      if (acc_done && running) begin
        out_reg <= acc_in[ACC_IN_W-1:ACC_DROP];
        out_new <= 1'b1;
      end
    end
  end

  // Output formatter muxes
  always_comb begin
    next_data_out = OUT_RST;
    if (sel.final_stage_bypass) begin
      next_data_out[23:16] = out_reg[POS_HI_LOW -: 8];
      next_data_out[15:0] = out_reg[POS_LO_BYP -: DATA_W];
    end else begin
      next_data_out[15:0] = out_reg[POS_LO_NRM -: DATA_W];
      if (sel.upper_byte_select) begin
        next_data_out[23:16] = out_reg[POS_HI_SEL -: 8];
      end else begin
        next_data_out[23:16] = out_reg[POS_HI_LOW -: 8];
      end
    end
  end

  // Bus loads a clock before the strobe rises, strobe one clock wide
  always_ff @(posedge clk) begin
    if (rst) begin
      data_out <= OUT_RST;
      data_ready <= 1'b0;
    end else begin
      if (out_new) begin
        data_out <= next_data_out;
      end
      // One clock wide, a clock after the bus has loaded
      data_ready <= strobe_arm;
    end
  end

  // Strobe delayed one clock after data so the bus is settled
  always_ff @(posedge clk) begin
    if (rst) begin
      strobe_arm <= 1'b0;
    end else begin
      strobe_arm <= out_new;
    end
  end

  property p_one_strobe;
    @(posedge clk) disable iff (rst)
      strobe_arm |=> data_ready ##1 !data_ready;
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("strobe not one clock after result");

  property p_stable;
    @(posedge clk) disable iff (rst)
      $rose(data_ready) |-> $stable(data_out);
  endproperty
  a_stable: assert property (p_stable)
    else $error("output bus moved at strobe");

  property p_reset_start;
    @(posedge clk) rst |=> !internal_start;
  endproperty
  a_reset_start: assert property (p_reset_start)
    else $error("internal start active after reset");

  property p_sync_start;
    @(posedge clk) disable iff (rst)
      (sync_prev && !sync_start_n) |=> internal_start ##1 running;
  endproperty
  a_sync_start: assert property (p_sync_start)
    else $error("sync start did not start block");

  property p_cascade;
    @(posedge clk) disable iff (rst)
      $fell(start_cascade_out_n) |=> internal_start;
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("cascade out not aligned with start");

  property p_async;
    @(posedge clk) disable iff (rst)
      $fell(async_start_n) ##1 !async_start_n ##1 !async_start_n
        |=> !start_cascade_out_n;
  endproperty
  a_async: assert property (p_async)
    else $error("async start not seen on cascade");

  property p_no_level;
    @(posedge clk) disable iff (rst)
      (!sync_prev && !sync_start_n && async_prev == async_sync)
        |=> !internal_start;
  endproperty
  a_no_level: assert property (p_no_level)
    else $error("start taken from a low level");

  property p_idle;
    @(posedge clk) disable iff (rst) !running |-> !data_accept;
  endproperty
  a_idle: assert property (p_idle)
    else $error("data accepted before start");

  property p_latch;
    @(posedge clk) disable iff (rst)
      (acc_done && running) |=> out_reg == $past(acc_in[42:3]);
  endproperty
  a_latch: assert property (p_latch)
    else $error("output register not latched");

  property p_fmt;
    @(posedge clk) disable iff (rst)
      (out_new && !sel.final_stage_bypass && sel.upper_byte_select)
        |=> data_out == out_reg[39:16];
  endproperty
  a_fmt: assert property (p_fmt)
    else $error("upper byte select format wrong");

endmodule

/* File: fosc_capture.sv */
// External capture register fed by the output-valid strobe
module fosc_capture
  import fosc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic data_ready,
  input wire logic [OUT_W-1:0] data_out,
  output logic [OUT_W-1:0] word,
  output int n_words
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ready_q;
  // Latch the bus once per rising strobe edge
  always_ff @(posedge clk) begin
    ready_q <= data_ready;
    if (rst) begin
      word <= OUT_RST;
      n_words <= 0;
    end else if (data_ready && !ready_q) begin
      word <= data_out;
      n_words <= n_words + 1;
    end
  end
endmodule

/* File: fosc_bench.sv */
// Self-checking bench for the output formatter and start control
module fosc_bench
  import fosc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic rst, async_start_n, sync_start_n, filter_disable;
  logic acc_done, data_in_valid, casc_n, internal_start, running;
  logic data_accept, data_ready;
  fosc_sel_s sel;
  logic [ACC_IN_W-1:0] acc_in;
  logic [OUT_W-1:0] data_out, word;
  int n_words, failures = 0, n_checks = 0, i, n0;

  // Clock, design and capture partner
  always #25 clk = ~clk;
  fosc_top i_dut (.clk(clk), .rst(rst), .async_start_n(async_start_n),
    .sync_start_n(sync_start_n), .filter_disable(filter_disable),
    .sel(sel), .acc_in(acc_in), .acc_done(acc_done),
    .data_in_valid(data_in_valid), .start_cascade_out_n(casc_n),
    .internal_start(internal_start), .running(running),
    .data_accept(data_accept), .data_out(data_out),
    .data_ready(data_ready));
  fosc_capture i_cap (.clk(clk), .rst(rst), .data_ready(data_ready),
    .data_out(data_out), .word(word), .n_words(n_words));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic check(input logic [OUT_W-1:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected output word from the select settings
  function automatic logic [OUT_W-1:0] exp_out(fosc_sel_s s,
      logic [ACC_IN_W-1:0] a);
    logic [ACC_W-1:0] r;
    r = a[ACC_IN_W-1:ACC_DROP];
    if (s.final_stage_bypass) return {r[15:8], r[15:0]};
    return {s.upper_byte_select ? r[39:32] : r[15:8], r[31:16]};
  endfunction

  task automatic pulse_result(input logic [ACC_IN_W-1:0] a);
    acc_in = a;
    acc_done = 1;
    tick(1);
    acc_done = 0;
    tick(4);
  endtask

  task automatic do_reset;
    rst = 1;
    tick(2);
    rst = 0;
  endtask

  // Results offered before any start are ignored
  task automatic t_idle;
    pulse_result(43'h6b4c2d1e0f7);
    check(running, 0);
    check(data_accept, 0);
    check(n_words[23:0], 0);
    check(internal_start, 0);
    check(casc_n, 1);
  endtask

  // Synchronous start with the async input held high
  task automatic t_sync;
    sync_start_n = 0;
    for (i = 0; i < 4 && internal_start !== 1'b1; i++) tick(1);
    check(internal_start, 1);
    tick(1);
    check(internal_start, 0);
    check(running, 1);
    sync_start_n = 1;
    tick(1);
    check(internal_start, 0);
    check(data_accept, 1);
  endtask

  // Disable pauses the block; results refused until restart
  task automatic t_pause;
    data_in_valid = 0;
    tick(1);
    check(data_accept, 0);
    data_in_valid = 1;
    filter_disable = 1;
    tick(1);
    check(running, 0);
    filter_disable = 0;
    n0 = n_words;
    pulse_result(43'h1f2e3d4c5b6);
    check(n_words[23:0], n0);
    check(running, 0);
  endtask

  // Every select setting, one strobe per result
  task automatic t_results;
    for (int k = 0; k < 4; k++) begin
      sel = fosc_sel_s'(k[1:0]);
      n0 = n_words;
      pulse_result(43'h6b4c2d1e0f7 + k * 43'h0123456789a);
      check(word, exp_out(sel, acc_in));
      check(data_out, word);
      check(n_words[23:0], n0 + 1);
    end
  endtask

  // Asynchronous start drives the cascade output
  task automatic t_async;
    do_reset();
    check(running, 0);
    async_start_n = 0;
    for (i = 0; i < 6 && casc_n !== 1'b0; i++) tick(1);
    check(casc_n, 0);
    check(internal_start, 0);
    async_start_n = 1;
    tick(1);
    check(casc_n, 1);
    check(internal_start, 1);
    tick(1);
    check(running, 1);
  endtask

  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1;
    async_start_n = 1;
    sync_start_n = 1;
    filter_disable = 0;
    sel = fosc_sel_s'(2'h0);
    acc_in = 43'h0;
    acc_done = 0;
    data_in_valid = 1;
    do_reset();
    t_idle();
    t_sync();
    t_results();
    t_pause();
    t_async();
    report_and_stop();
  end

  // Watchdog against a hang
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end
endmodule
